// ===== design/crs_defs.vh
// constants for the cpu core register set
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH
// flag bit positions
`define CRS_F_GIE      0
`define CRS_F_ZERO     1
`define CRS_F_CARRY    2
`define CRS_F_SUPER    3
`define CRS_F_BANK     4
// writable flag bits: bank, carry, zero, irq enable
`define CRS_F_WMASK    8'h17
// reset values
`define CRS_F_RESET    8'h02
`define CRS_REG_RESET  8'h00
`define CRS_PC_RESET   16'h0000
// explicit register-space address of the flags register
`define CRS_F_ADDR     8'hf7
// addressing modes
`define CRS_MODE_IMM   2'h0
`define CRS_MODE_DIR   2'h1
`define CRS_MODE_IDX   2'h2
// destinations
`define CRS_DST_A      2'h0
`define CRS_DST_F      2'h1
`define CRS_DST_SP     2'h2
`define CRS_DST_X      2'h3
// alu operations
`define CRS_OP_MOV     3'h0
`define CRS_OP_ADD     3'h1
`define CRS_OP_AND     3'h2
`define CRS_OP_OR      3'h3
`define CRS_OP_XOR     3'h4
`define CRS_OP_SUB     3'h5
`define CRS_OP_SHL     3'h6
`define CRS_OP_SHR     3'h7
// stack pointer actions
`define CRS_SP_HOLD    3'h0
`define CRS_SP_PUSH    3'h1
`define CRS_SP_POP     3'h2
`define CRS_SP_CALL    3'h3
`define CRS_SP_RET     3'h4
`define CRS_SP_INTERRUPT_EXIT_OP    3'h5
`define CRS_SP_ADD     3'h6
`define CRS_SP_SWAP    3'h7
// instruction length of the source modes in bytes
`define CRS_SRC_LEN    16'h0002
`endif

// ===== design/crs_core_regs.v
// cpu core register set with source immediate, direct and indexed modes
`timescale 1ns/10ps
`include "crs_defs.vh"

// Summary of operation
// - sixteen-bit program counter covers program memory
// - counter also shown as high, low bytes
// - accumulator takes results aimed at it
// - index register offsets indexed source addresses
// - stack pointer moves on stack instructions
// - core registers other than the flags hidden from register space
// - zero bit1, carry bit2, privilege bit3
// - flags bit0 is global interrupt enable
// - privilege bit read-only, shows supervisor state
// - carry follows carry of alu operation
// - zero set when alu result is zero
// - flag update depends on the instruction
// - flags written only by and/or
// - flags readable only at address f7
// - flags bit4 selects register bank
// - reset loads zero flag, all else zero
// - immediate mode uses operand, two bytes
// - direct mode fetches operand address, two bytes
// - indexed mode adds operand to index
module crs_core_regs (
  input  wire       clk_in,        // cpu clock
  input  wire       arst_n_in,     // asynchronous reset, active low
  input  wire       exec_in,       // one-cycle pulse: execute instruction
  input  wire [1:0] mode_in,       // source addressing mode
  input  wire [2:0] op_in,         // alu operation
  input  wire [1:0] dst_in,        // destination register
  input  wire       second_x_in,   // second source is index, not acc
  input  wire [7:0] operand_in,    // operand 1 byte
  input  wire [7:0] src_data_in,   // data fetched from memory/reg space
  input  wire       src_is_reg_in, // fetch targets register space
  input  wire [2:0] sp_op_in,      // stack pointer action
  input  wire [7:0] sp_arg_in,     // add amount or swap value for sp
  input  wire       super_in,      // cpu runs supervisor code
  input  wire       jump_in,       // load program counter
  input  wire [15:0] jump_addr_in, // program counter target
  output reg  [7:0] acc_out,       // accumulator
  output reg  [7:0] index_out,     // index register
  output reg  [7:0] sp_out,        // stack top pointer
  output reg  [7:0] flags_out,     // flags as read at address f7
  output reg  [7:0] pc_high_out,   // program counter high byte
  output reg  [7:0] pc_low_out,    // program counter low byte
  output reg  [7:0] src_addr_out,  // source address for the fetch
  output reg        src_reg_out,   // fetch is to register space
  output reg        bank_sel_out,  // register bank select
  output reg        irq_en_out,    // global interrupt enable
  output reg        f_read_ok_out  // fetch address hits the flags
);

  // architectural state
  reg  [7:0]  acc_q;       // accumulator
  reg  [7:0]  index_q;     // index register
  reg  [7:0]  sp_q;        // stack top pointer
  reg  [7:0]  flags_q;     // flags, reserved bits held at zero
  reg  [15:0] pc_q;        // program counter
  reg         super_s1_q;  // supervisor state synchroniser stage 1
  reg         super_s2_q;  // supervisor state synchroniser stage 2

  // combinational datapath
  reg  [7:0]  src_val;     // first source value
  reg  [7:0]  second_val;  // second source value
  reg  [8:0]  alu_res;     // result with carry out
  reg         alu_logic;   // operation changes carry and zero
  reg  [7:0]  src_addr_d;  // source address for the fetch
  reg  [7:0]  flags_d;     // next flags
  reg  [7:0]  sp_d;        // next stack pointer

  // flags as software sees them, with reserved bits forced low
  function [7:0] flag_view;
    input [7:0] f;
    input       sup;
    begin
      flag_view = (f & `CRS_F_WMASK);
      flag_view[`CRS_F_SUPER] = sup;
    end
  endfunction

  // supervisor level comes from outside logic; resynchronise it
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      super_s1_q <= 1'b0;
      super_s2_q <= 1'b0;
    end else begin
      super_s1_q <= super_in;
      super_s2_q <= super_s1_q;
    end
  end

  // source address: direct uses operand, indexed adds the index
  always @* begin
    case (mode_in)
      `CRS_MODE_IDX: src_addr_d = operand_in + index_q;
      `CRS_MODE_DIR: src_addr_d = operand_in;
      default:       src_addr_d = operand_in;
    endcase
  end

  // pick operands and run the alu
  always @* begin
    // immediate takes the operand byte, the others the fetched byte
    if (mode_in == `CRS_MODE_IMM) begin
      src_val = operand_in;
    end else begin
      src_val = src_data_in;
    end
    // and/or into flags combine with the flags themselves
    if (mode_in == `CRS_MODE_IMM && dst_in == `CRS_DST_F) begin
      second_val = flags_q;
    end else if (second_x_in) begin
      second_val = index_q;
    end else begin
      second_val = acc_q;
    end
    alu_logic = 1'b1;
    case (op_in)
      `CRS_OP_MOV: begin
        alu_res   = {1'b0, src_val};
        alu_logic = 1'b0;
      end
      `CRS_OP_ADD: alu_res = {1'b0, second_val} + {1'b0, src_val};
      `CRS_OP_SUB: alu_res = {1'b0, second_val} - {1'b0, src_val};
      `CRS_OP_AND: alu_res = {1'b0, second_val & src_val};
      `CRS_OP_OR:  alu_res = {1'b0, second_val | src_val};
      `CRS_OP_XOR: alu_res = {1'b0, second_val ^ src_val};
      `CRS_OP_SHL: alu_res = {src_val, 1'b0};
      `CRS_OP_SHR: alu_res = {src_val[0], 1'b0, src_val[7:1]};
      default: begin
        alu_res   = {1'b0, src_val};
        alu_logic = 1'b0;
      end
    endcase
  end

  // next flags value
  always @* begin
    flags_d = flags_q;
    if (exec_in) begin
      if (mode_in == `CRS_MODE_IMM && dst_in == `CRS_DST_F) begin
        // only and/or may write the flags; others leave them alone
        if (op_in == `CRS_OP_AND || op_in == `CRS_OP_OR) begin
          flags_d = alu_res[7:0] & `CRS_F_WMASK;
        end
      end else if (alu_logic) begin
        flags_d[`CRS_F_CARRY] = alu_res[8];
        flags_d[`CRS_F_ZERO]  = (alu_res[7:0] == 8'h00);
      end
    end
  end

  // next stack pointer
  always @* begin
    sp_d = sp_q;
    if (exec_in && mode_in == `CRS_MODE_IMM && dst_in == `CRS_DST_SP) begin
      sp_d = alu_res[7:0];
    end else begin
      case (sp_op_in)
        `CRS_SP_PUSH: sp_d = sp_q + 8'h01;
        `CRS_SP_POP:  sp_d = sp_q - 8'h01;
        `CRS_SP_CALL: sp_d = sp_q + 8'h02;  // two return bytes
        `CRS_SP_RET:  sp_d = sp_q - 8'h02;
        `CRS_SP_INTERRUPT_EXIT_OP: sp_d = sp_q - 8'h03;  // return bytes and flags
        `CRS_SP_ADD:  sp_d = sp_q + sp_arg_in;
        `CRS_SP_SWAP: sp_d = sp_arg_in;
        default:      sp_d = sp_q;
      endcase
    end
  end

  // state registers; execution, stack actions and jumps change them, no store path exists
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_q   <= `CRS_REG_RESET;
      index_q <= `CRS_REG_RESET;
      sp_q    <= `CRS_REG_RESET;
      flags_q <= `CRS_F_RESET;
      pc_q    <= `CRS_PC_RESET;
    end else begin
      flags_q <= flags_d;
      sp_q    <= sp_d;
      if (exec_in) begin
        // immediate may target any of four; other modes only a or x
        if (dst_in == `CRS_DST_A) begin
          acc_q <= alu_res[7:0];
        end else if (dst_in == `CRS_DST_X) begin
          index_q <= alu_res[7:0];
        end
      end
      // jumps win over stepping past a two-byte instruction
      if (jump_in) begin
        pc_q <= jump_addr_in;
      end else if (exec_in) begin
        pc_q <= pc_q + `CRS_SRC_LEN;
      end
    end
  end

  // registered outputs
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_out       <= `CRS_REG_RESET;
      index_out     <= `CRS_REG_RESET;
      sp_out        <= `CRS_REG_RESET;
      flags_out     <= `CRS_F_RESET;
      pc_high_out   <= `CRS_REG_RESET;
      pc_low_out    <= `CRS_REG_RESET;
      src_addr_out  <= `CRS_REG_RESET;
      src_reg_out   <= 1'b0;
      bank_sel_out  <= 1'b0;
      irq_en_out    <= 1'b0;
      f_read_ok_out <= 1'b0;
    end else begin
      acc_out       <= acc_q;
      index_out     <= index_q;
      sp_out        <= sp_q;
      flags_out     <= flag_view(flags_q, super_s2_q);
      pc_high_out   <= pc_q[15:8];
      pc_low_out    <= pc_q[7:0];
      src_addr_out  <= src_addr_d;
      src_reg_out   <= src_is_reg_in;
      bank_sel_out  <= flags_q[`CRS_F_BANK];
      irq_en_out    <= flags_q[`CRS_F_GIE];
      // the flags answer a register read only at their own address
      f_read_ok_out <= src_is_reg_in &&
                       (src_addr_d == `CRS_F_ADDR);
    end
  end

endmodule // crs_core_regs

// ===== testbench/crs_core_regs_checker.sv
// concurrent checks on the core register set ports
`timescale 1ns/10ps
`include "crs_defs.vh"
module crs_core_regs_checker (
  input wire        clk_in,
  input wire        arst_n_in,
  input wire        exec_in,
  input wire  [1:0] mode_in,
  input wire  [2:0] op_in,
  input wire  [1:0] dst_in,
  input wire  [7:0] operand_in,
  input wire        src_is_reg_in,
  input wire  [2:0] sp_op_in,
  input wire        super_in,
  input wire        jump_in,
  input wire [15:0] jump_addr_in,
  input wire  [7:0] acc_out,
  input wire  [7:0] index_out,
  input wire  [7:0] sp_out,
  input wire  [7:0] flags_out,
  input wire  [7:0] pc_high_out,
  input wire  [7:0] pc_low_out,
  input wire  [7:0] src_addr_out,
  input wire        f_read_ok_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire [15:0] pc = {pc_high_out, pc_low_out}; // joined counter halves
  // a quiet cycle first, so the two-stage output still shows old state
  sequence quiet_s; !exec_in && !jump_in && sp_op_in == 3'h0; endsequence
  sequence step_s; exec_in && !jump_in; endsequence
  AST_RSVD: assert property (flags_out[7:5] == 3'h0)
    else $error("reserved flag bits not zero");
  AST_SUPER: assert property (super_in [*6] |-> flags_out[3])
    else $error("supervisor flag does not follow level");
  AST_PC_STEP: assert property (quiet_s ##1 step_s |-> ##2
    pc == $past(pc, 2) + 16'h2) else $error("pc did not step by two");
  AST_JUMP: assert property (jump_in |-> ##2
    pc == $past(jump_addr_in, 2)) else $error("pc halves miss target");
  AST_ACC_MOV: assert property (exec_in && mode_in == `CRS_MODE_IMM &&
    op_in == `CRS_OP_MOV && dst_in == `CRS_DST_A |-> ##2
    acc_out == $past(operand_in, 2)) else $error("acc missed operand");
  AST_FREAD: assert property (exec_in && mode_in == `CRS_MODE_DIR |=>
    f_read_ok_out == $past(src_is_reg_in && operand_in == 8'hf7))
    else $error("flags read decode wrong");
  AST_IDX: assert property (!exec_in ##1 exec_in &&
    mode_in == `CRS_MODE_IDX |=> src_addr_out == $past(operand_in) +
    index_out) else $error("indexed source address wrong");
  AST_PUSH: assert property (quiet_s ##1 (!exec_in &&
    sp_op_in == `CRS_SP_PUSH) |-> ##2 sp_out == $past(sp_out, 2) + 8'h1)
    else $error("push did not raise sp by one");
endmodule // crs_core_regs_checker
bind crs_core_regs crs_core_regs_checker crs_core_regs_checker_inst (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .exec_in(exec_in),
  .mode_in(mode_in), .op_in(op_in), .dst_in(dst_in),
  .operand_in(operand_in), .src_is_reg_in(src_is_reg_in),
  .sp_op_in(sp_op_in), .super_in(super_in), .jump_in(jump_in),
  .jump_addr_in(jump_addr_in), .acc_out(acc_out), .index_out(index_out),
  .sp_out(sp_out), .flags_out(flags_out), .pc_high_out(pc_high_out),
  .pc_low_out(pc_low_out), .src_addr_out(src_addr_out),
  .f_read_ok_out(f_read_ok_out));

// ===== testbench/cpu_core_register_set_bench.sv
// self-checking bench for the cpu core register set
`timescale 1ns/10ps
`include "crs_defs.vh"
module cpu_core_register_set_bench;
  logic clk_in = 0, arst_n_in = 0, exec_in = 0, second_x_in = 0;
  logic src_is_reg_in = 0, super_in = 0, jump_in = 0;
  logic [1:0] mode_in = 0, dst_in = 0;
  logic [2:0] op_in = 0, sp_op_in = 0;
  logic [7:0] operand_in = 0, src_data_in = 0, sp_arg_in = 0;
  logic [15:0] jump_addr_in = 0, pc_exp = 0; // pc_exp: expected counter
  wire [7:0] acc_out, index_out, sp_out, flags_out, pc_high_out;
  wire [7:0] pc_low_out, src_addr_out;
  wire src_reg_out, bank_sel_out, irq_en_out, f_read_ok_out;
  int miscompares = 0, n_compared = 0;
  crs_core_regs crs_core_regs_inst (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .exec_in(exec_in), .mode_in(mode_in),
    .op_in(op_in), .dst_in(dst_in), .second_x_in(second_x_in),
    .operand_in(operand_in), .src_data_in(src_data_in),
    .src_is_reg_in(src_is_reg_in), .sp_op_in(sp_op_in),
    .sp_arg_in(sp_arg_in), .super_in(super_in), .jump_in(jump_in),
    .jump_addr_in(jump_addr_in), .acc_out(acc_out),
    .index_out(index_out), .sp_out(sp_out), .flags_out(flags_out),
    .pc_high_out(pc_high_out), .pc_low_out(pc_low_out),
    .src_addr_out(src_addr_out), .src_reg_out(src_reg_out),
    .bank_sel_out(bank_sel_out), .irq_en_out(irq_en_out),
    .f_read_ok_out(f_read_ok_out));
  initial forever #4 clk_in = ~clk_in;
  task automatic report_and_stop;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one source-mode instruction; outputs settle two edges later
  task automatic ex(input logic [1:0] m, d, input logic [2:0] o,
                    input logic [7:0] opd, sd);
    mode_in = m; dst_in = d; op_in = o; operand_in = opd;
    src_data_in = sd; exec_in = 1;
    @(negedge clk_in) exec_in = 0;
    @(negedge clk_in) pc_exp += 16'h2;
    chk("pc", {pc_high_out, pc_low_out}, pc_exp);
  endtask
  // one stack action held for a single cycle
  task automatic sp(input logic [2:0] a, input logic [7:0] g, exp);
    sp_op_in = a; sp_arg_in = g;
    @(negedge clk_in) sp_op_in = 0;
    @(negedge clk_in) chk("sp", sp_out, exp);
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    arst_n_in = 1;
    @(negedge clk_in) chk("regs", {acc_out, index_out}, 0);
    chk("pcsp", {pc_high_out, pc_low_out | sp_out}, 0);
    chk("flags", flags_out, 8'h02);
    ex(`CRS_MODE_IMM, `CRS_DST_A, `CRS_OP_MOV, 8'h07, 0);
    chk("acc", acc_out, 8'h07);
    ex(`CRS_MODE_IMM, `CRS_DST_X, `CRS_OP_MOV, 8'h10, 0);
    chk("index", index_out, 8'h10);
    ex(`CRS_MODE_IMM, `CRS_DST_A, `CRS_OP_ADD, 8'hf9, 0);
    chk("acc", acc_out, 8'h00);
    chk("flags", flags_out, 8'h06);
    ex(`CRS_MODE_IMM, `CRS_DST_A, `CRS_OP_ADD, 8'h01, 0);
    chk("flags", flags_out, 8'h00);
    ex(`CRS_MODE_IMM, `CRS_DST_F, `CRS_OP_OR, 8'hf9, 0);
    chk("flags", flags_out, 8'h11);
    chk("bank irq", {bank_sel_out, irq_en_out}, 2'b11);
    ex(`CRS_MODE_IMM, `CRS_DST_F, `CRS_OP_AND, 8'h01, 0);
    chk("flags", flags_out, 8'h01);
    ex(`CRS_MODE_IMM, `CRS_DST_F, `CRS_OP_MOV, 8'h02, 0);
    chk("flags", flags_out, 8'h01);
    src_is_reg_in = 1;
    ex(`CRS_MODE_DIR, `CRS_DST_A, `CRS_OP_MOV, 8'hf7, 8'h5a);
    chk("acc", acc_out, 8'h5a);
    chk("ft", {src_reg_out, f_read_ok_out, src_addr_out}, 10'h3f7);
    // aim at acc so the index, and with it the address, stays steady
    ex(`CRS_MODE_IDX, `CRS_DST_A, `CRS_OP_MOV, 8'h08, 8'h33);
    chk("ft", {src_reg_out, f_read_ok_out, src_addr_out}, 10'h218);
    chk("index", index_out, 8'h10);
    chk("acc", acc_out, 8'h33);
    sp(`CRS_SP_PUSH, 0, 8'h01); sp(`CRS_SP_CALL, 0, 8'h03);
    sp(`CRS_SP_POP, 0, 8'h02); sp(`CRS_SP_RET, 0, 8'h00);
    sp(`CRS_SP_SWAP, 8'h40, 8'h40); sp(`CRS_SP_ADD, 8'h05, 8'h45);
    sp(`CRS_SP_INTERRUPT_EXIT_OP, 0, 8'h42);
    jump_addr_in = 16'h1ffe; jump_in = 1; pc_exp = 16'h1ffe;
    @(negedge clk_in) jump_in = 0;
    @(negedge clk_in) chk("pc", {pc_high_out, pc_low_out}, pc_exp);
    ex(`CRS_MODE_IMM, `CRS_DST_A, `CRS_OP_MOV, 8'h00, 0);
    super_in = 1;
    repeat (8) @(negedge clk_in);
    ex(`CRS_MODE_IMM, `CRS_DST_F, `CRS_OP_AND, 8'h00, 0);
    chk("flags", flags_out, 8'h08);
    arst_n_in = 0; // second reset in mid-run
    @(negedge clk_in) chk("flags", flags_out, 8'h02);
    super_in = 0;
    arst_n_in = 1;
    @(negedge clk_in) chk("flags", flags_out, 8'h02);
    @(negedge clk_in) chk("pc", {pc_high_out, pc_low_out}, 16'h0000);
    repeat (2) @(negedge clk_in);
    report_and_stop;
  end
  // cuts a hang short well beyond the expected run of about 64 cycles
  initial begin
    #(8 * 3000);
    miscompares++;
    report_and_stop;
  end
endmodule // cpu_core_register_set_bench
